// [shared/pin_routing_pkg.sv]
// constants for the audio interface pin routing block
`default_nettype none
package pin_routing_pkg;
  localparam logic [7:0] addr_clock_routing = 8'h11;
  localparam logic [7:0] addr_input_routing = 8'h12;
  localparam logic [7:0] addr_density_config = 8'h13;
  localparam logic [7:0] addr_pin_misc = 8'h14;
  localparam logic [7:0] addr_mic_supply = 8'h15;

  localparam logic [7:0] reset_clock_routing = 8'h80;
  localparam logic [7:0] reset_input_routing = 8'h00;
  localparam logic [7:0] reset_density_config = 8'h00;
  localparam logic [7:0] reset_pin_misc = 8'h00;
  localparam logic [7:0] reset_mic_supply = 8'h00;

  // writable bit masks; other bits are reserved
  localparam logic [7:0] mask_clock_routing = 8'hfe;
  localparam logic [7:0] mask_input_routing = 8'hfc;
  localparam logic [7:0] mask_density_config = 8'hff;
  localparam logic [7:0] mask_pin_misc = 8'hf1;
  localparam logic [7:0] mask_mic_supply = 8'hc0;

  // field positions
  localparam int primary_input_enable_bit = 7;
  localparam int frame_source_lsb = 4;
  localparam int bitclock_source_lsb = 1;
  localparam int input_source_lsb = 5;
  localparam int input2_source_lsb = 2;
  localparam int chan1_type_bit = 7;
  localparam int chan2_type_bit = 6;
  localparam int pair12_edge_bit = 5;
  localparam int pair34_edge_bit = 4;
  localparam int pair12_source_lsb = 2;
  localparam int pair34_source_lsb = 0;
  localparam int override_bit = 7;
  localparam int dual_use_bit = 6;
  localparam int shutdown_pin_lsb = 4;
  localparam int aux_enable_bit = 0;
  localparam int mic_pin_lsb = 6;

  // selector codes
  localparam logic [2:0] sel_off = 3'h0;
  localparam logic [2:0] sel_multi_one = 3'h1;
  localparam logic [2:0] sel_input_two = 3'h2;
  localparam logic [2:0] sel_input_one = 3'h3;
  localparam logic [2:0] sel_serial_out = 3'h4;
  localparam logic [2:0] sel_primary = 3'h5;
endpackage : pin_routing_pkg
`default_nettype wire

// [verilog/pin_select3.sv]
// three-bit source selector shared by the serial port routes
`timescale 1ns/1ps
`default_nettype none
module pin_select3
  import pin_routing_pkg::*;
(
  // selection
  input wire logic [2:0] code,
  input wire logic allow_serial_out,
  // sources
  input wire logic multi_one,
  input wire logic input_two,
  input wire logic input_one,
  input wire logic serial_out,
  input wire logic primary,
  // result
  output logic value,
  output logic active
);
  always_comb
  begin
    value = 1'b0;
    active = 1'b1;
    case (code)
      sel_multi_one: value = multi_one;
      sel_input_two: value = input_two;
      sel_input_one: value = input_one;
      sel_primary: value = primary;
      sel_serial_out:
      begin
        value = allow_serial_out & serial_out;
        active = allow_serial_out;
      end
      default: active = 1'b0;
    endcase
  end
endmodule : pin_select3
`default_nettype wire

// [verilog/pin_select2.sv]
// two-bit general pin selector
`timescale 1ns/1ps
`default_nettype none
module pin_select2
  import pin_routing_pkg::*;
(
  // selection
  input wire logic [1:0] code,
  // sources
  input wire logic multi_one,
  input wire logic input_two,
  input wire logic input_one,
  // result
  output logic value,
  output logic active
);
  always_comb
  begin
    value = 1'b0;
    active = 1'b1;
    case ({1'b0, code})
      sel_multi_one: value = multi_one;
      sel_input_two: value = input_two;
      sel_input_one: value = input_one;
      default: active = 1'b0;
    endcase
  end
endmodule : pin_select2
`default_nettype wire

// [verilog/audio_interface_pin_routing.sv]
// register file and pin routing for the serial ports and density inputs
`timescale 1ns/1ps
`default_nettype none
module audio_interface_pin_routing
  import pin_routing_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic reg_write,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // pins, asynchronous
  input wire logic multi_pin_one,
  input wire logic input_pin_two,
  input wire logic input_pin_one,
  input wire logic serial_in_pin,
  input wire logic serial_out_pin_in,
  input wire logic primary_frame_sync,
  input wire logic primary_bit_clock,
  input wire logic density_mod_clock,
  // other device controls
  input wire logic converter_power_control,
  input wire logic [3:0] out_function_select,
  // primary port
  output logic primary_data_in,
  // secondary port
  output logic secondary_enable,
  output logic secondary_frame_sync,
  output logic secondary_bit_clock,
  output logic secondary_data_in,
  output logic secondary_data_in_valid,
  output logic secondary_data_in2,
  output logic secondary_data_in2_valid,
  // density inputs
  output logic chan1_digital,
  output logic chan2_digital,
  output logic [3:0] density_sample,
  output logic [3:0] density_sample_strobe,
  // misc pin functions
  output logic converter_shutdown,
  output logic aux_function_enable,
  output logic mic_supply_enable,
  output logic serial_out_is_input,
  output logic [3:0] serial_out_function
);
  // registers
  logic [7:0] clock_routing, next_clock_routing;
  logic [7:0] input_routing, next_input_routing;
  logic [7:0] density_config, next_density_config;
  logic [7:0] pin_misc, next_pin_misc;
  logic [7:0] mic_supply, next_mic_supply;

  // register writes, reserved bits forced low
  always_comb
  begin
    next_clock_routing = clock_routing;
    next_input_routing = input_routing;
    next_density_config = density_config;
    next_pin_misc = pin_misc;
    next_mic_supply = mic_supply;
    if (reg_write)
    begin
      case (reg_addr)
        addr_clock_routing: next_clock_routing = reg_wdata & mask_clock_routing;
        addr_input_routing: next_input_routing = reg_wdata & mask_input_routing;
        addr_density_config: next_density_config = reg_wdata & mask_density_config;
        addr_pin_misc: next_pin_misc = reg_wdata & mask_pin_misc;
        addr_mic_supply: next_mic_supply = reg_wdata & mask_mic_supply;
        default: ;
      endcase
    end
  end

  // register update
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clock_routing <= reset_clock_routing;
      input_routing <= reset_input_routing;
      density_config <= reset_density_config;
      pin_misc <= reset_pin_misc;
      mic_supply <= reset_mic_supply;
    end
    else
    begin
      clock_routing <= next_clock_routing;
      input_routing <= next_input_routing;
      density_config <= next_density_config;
      pin_misc <= next_pin_misc;
      mic_supply <= next_mic_supply;
    end
  end

  // read mux, unmapped reads zero
  always_comb
  begin
    case (reg_addr)
      addr_clock_routing: reg_rdata = clock_routing;
      addr_input_routing: reg_rdata = input_routing;
      addr_density_config: reg_rdata = density_config;
      addr_pin_misc: reg_rdata = pin_misc;
      addr_mic_supply: reg_rdata = mic_supply;
      default: reg_rdata = 8'h00;
    endcase
  end

  // pin synchronisers, one generate loop over all pins
  localparam int num_pins = 8;
  logic [num_pins-1:0] pin_raw, pin_meta, pin_sync;
  assign pin_raw = {density_mod_clock, primary_bit_clock, primary_frame_sync, serial_out_pin_in,
                    serial_in_pin, input_pin_one, input_pin_two, multi_pin_one};
  generate
    for (genvar i = 0; i < num_pins; i++)
    begin : g_sync
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          pin_meta[i] <= 1'b0;
          pin_sync[i] <= 1'b0;
        end
        else
        begin
          pin_meta[i] <= pin_raw[i];
          pin_sync[i] <= pin_meta[i];
        end
      end
    end
  endgenerate

  // synchronised pin levels
  logic s_multi, s_in2, s_in1, s_serial_in, s_serial_out, s_pfs, s_pbclk, s_dclk;
  assign {s_dclk, s_pbclk, s_pfs, s_serial_out, s_serial_in, s_in1, s_in2, s_multi} = pin_sync;

  // fields
  logic [2:0] frame_code, bclk_code, din_code, din2_code;
  logic [1:0] pair12_code, pair34_code, shutdown_code, mic_code;
  logic dual_use, override_en, primary_en;
  assign primary_en = clock_routing[primary_input_enable_bit];
  assign frame_code = clock_routing[frame_source_lsb +: 3];
  assign bclk_code = clock_routing[bitclock_source_lsb +: 3];
  assign din_code = input_routing[input_source_lsb +: 3];
  assign din2_code = input_routing[input2_source_lsb +: 3];
  assign pair12_code = density_config[pair12_source_lsb +: 2];
  assign pair34_code = density_config[pair34_source_lsb +: 2];
  assign override_en = pin_misc[override_bit];
  assign dual_use = pin_misc[dual_use_bit];
  assign shutdown_code = pin_misc[shutdown_pin_lsb +: 2];
  assign mic_code = mic_supply[mic_pin_lsb +: 2];

  // primary data input gate
  logic primary_din;
  assign primary_din = primary_en & s_serial_in;

  // serial out pin usable as input when dual use or selected as input
  logic serial_out_input;
  assign serial_out_input = dual_use | (out_function_select == 4'h1);

  // secondary port frame sync and bit clock sources
  logic fs_val, fs_act, bc_val, bc_act;
  logic d1_val, d1_act, d2_val, d2_act;
  pin_select3 u_frame (
    .code(frame_code),
    .allow_serial_out(1'b0),
    .multi_one(s_multi),
    .input_two(s_in2),
    .input_one(s_in1),
    .serial_out(1'b0),
    .primary(s_pfs),
    .value(fs_val),
    .active(fs_act)
  );

  pin_select3 u_bclk (
    .code(bclk_code),
    .allow_serial_out(1'b0),
    .multi_one(s_multi),
    .input_two(s_in2),
    .input_one(s_in1),
    .serial_out(1'b0),
    .primary(s_pbclk),
    .value(bc_val),
    .active(bc_act)
  );

  // secondary port data input sources
  pin_select3 u_din (
    .code(din_code),
    .allow_serial_out(serial_out_input),
    .multi_one(s_multi),
    .input_two(s_in2),
    .input_one(s_in1),
    .serial_out(s_serial_out),
    .primary(primary_din),
    .value(d1_val),
    .active(d1_act)
  );

  pin_select3 u_din2 (
    .code(din2_code),
    .allow_serial_out(serial_out_input),
    .multi_one(s_multi),
    .input_two(s_in2),
    .input_one(s_in1),
    .serial_out(s_serial_out),
    .primary(primary_din),
    .value(d2_val),
    .active(d2_act)
  );

  // density data sources, input pin one may be overridden
  logic in1_density;
  assign in1_density = override_en ? s_serial_in : s_in1;
  logic p12_val, p12_act;
  logic p34_val, p34_act;
  pin_select2 u_pair12 (
    .code(pair12_code),
    .multi_one(s_multi),
    .input_two(s_in2),
    .input_one(in1_density),
    .value(p12_val),
    .active(p12_act)
  );

  pin_select2 u_pair34 (
    .code(pair34_code),
    .multi_one(s_multi),
    .input_two(s_in2),
    .input_one(in1_density),
    .value(p34_val),
    .active(p34_act)
  );

  // converter shutdown and microphone supply pins
  logic sd_val, sd_act;
  logic mic_val, mic_act;
  pin_select2 u_shutdown (
    .code(shutdown_code),
    .multi_one(s_multi),
    .input_two(s_in2),
    .input_one(s_in1),
    .value(sd_val),
    .active(sd_act)
  );

  pin_select2 u_mic (
    .code(mic_code),
    .multi_one(s_multi),
    .input_two(s_in2),
    .input_one(s_in1),
    .value(mic_val),
    .active(mic_act)
  );

  // density clock edge detection
  logic dclk_prev, next_dclk_prev;
  logic rise, fall;
  assign next_dclk_prev = s_dclk;
  assign rise = s_dclk & ~dclk_prev;
  assign fall = ~s_dclk & dclk_prev;

  // latch edge per channel: bit clear means odd channel on fall
  logic [3:0] ch_edge;
  assign ch_edge[0] = density_config[pair12_edge_bit] ? rise : fall;
  assign ch_edge[1] = density_config[pair12_edge_bit] ? fall : rise;
  assign ch_edge[2] = density_config[pair34_edge_bit] ? rise : fall;
  assign ch_edge[3] = density_config[pair34_edge_bit] ? fall : rise;
  logic [3:0] ch_active, ch_data;
  assign ch_active = {p34_act, p34_act, p12_act, p12_act};
  assign ch_data = {p34_val, p34_val, p12_val, p12_val};

  // output registers
  logic [3:0] next_sample, next_strobe;
  logic next_pdin, next_sfs, next_sbclk, next_sen;
  logic next_sd1, next_sd1v, next_sd2, next_sd2v;
  logic next_shutdown, next_mic;
  always_comb
  begin
    next_strobe = ch_edge & ch_active;
    next_sample = density_sample;
    for (int c = 0; c < 4; c++)
    begin
      if (next_strobe[c])
        next_sample[c] = ch_data[c];
    end
    next_pdin = primary_din;
    next_sen = fs_act & bc_act;
    next_sfs = fs_val & next_sen;
    next_sbclk = bc_val & next_sen;
    next_sd1 = d1_val;
    next_sd1v = d1_act;
    next_sd2 = d2_val;
    next_sd2v = d2_act;
    next_shutdown = ~converter_power_control | (sd_act & sd_val);
    next_mic = mic_act & mic_val;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dclk_prev <= 1'b0;
      density_sample <= 4'h0;
      density_sample_strobe <= 4'h0;
      primary_data_in <= 1'b0;
      secondary_enable <= 1'b0;
      secondary_frame_sync <= 1'b0;
      secondary_bit_clock <= 1'b0;
      secondary_data_in <= 1'b0;
      secondary_data_in_valid <= 1'b0;
      secondary_data_in2 <= 1'b0;
      secondary_data_in2_valid <= 1'b0;
      converter_shutdown <= 1'b1;
      mic_supply_enable <= 1'b0;
    end
    else
    begin
      dclk_prev <= next_dclk_prev;
      density_sample <= next_sample;
      density_sample_strobe <= next_strobe;
      primary_data_in <= next_pdin;
      secondary_enable <= next_sen;
      secondary_frame_sync <= next_sfs;
      secondary_bit_clock <= next_sbclk;
      secondary_data_in <= next_sd1;
      secondary_data_in_valid <= next_sd1v;
      secondary_data_in2 <= next_sd2;
      secondary_data_in2_valid <= next_sd2v;
      converter_shutdown <= next_shutdown;
      mic_supply_enable <= next_mic;
    end
  end

  // configuration outputs, combinational from registers and out_function_select
  assign chan1_digital = density_config[chan1_type_bit];
  assign chan2_digital = density_config[chan2_type_bit];
  assign aux_function_enable = pin_misc[aux_enable_bit];
  assign serial_out_is_input = serial_out_input;
  assign serial_out_function = dual_use ? 4'h0 : out_function_select;
endmodule : audio_interface_pin_routing
`default_nettype wire

// [verif/pin_routing_checker.sv]
// assertions on the pin routing block ports
`timescale 1ns/1ps
`default_nettype none
module pin_routing_checker (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic reg_write,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // controls
  input wire logic converter_power_control,
  input wire logic [3:0] out_function_select,
  // outputs
  input wire logic primary_data_in,
  input wire logic secondary_enable,
  input wire logic chan1_digital,
  input wire logic chan2_digital,
  input wire logic converter_shutdown,
  input wire logic aux_function_enable,
  input wire logic mic_supply_enable,
  input wire logic serial_out_is_input,
  input wire logic [3:0] serial_out_function
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_UNMAPPED_ZERO: assert property (!(reg_addr inside {[8'h11:8'h15]}) |-> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_CHAN1_TYPE: assert property (reg_write && reg_addr == 8'h13
    |=> chan1_digital == $past(reg_wdata[7]))
    else $error("channel 1 type wrong");
  AST_CHAN2_TYPE: assert property (reg_write && reg_addr == 8'h13
    |=> chan2_digital == $past(reg_wdata[6]))
    else $error("channel 2 type wrong");
  AST_AUX_ENABLE: assert property (reg_write && reg_addr == 8'h14
    |=> aux_function_enable == $past(reg_wdata[0]))
    else $error("aux enable wrong");
  AST_PRIMARY_GATE: assert property (reg_write && reg_addr == 8'h11 && !reg_wdata[7]
    ##1 !reg_write[*2] |=> !primary_data_in)
    else $error("primary input not gated");
  AST_SECONDARY_OFF: assert property (reg_write && reg_addr == 8'h11 && reg_wdata[6:4] == 3'h0
    ##1 !reg_write[*2] |=> !secondary_enable)
    else $error("secondary port not disabled");
  AST_MIC_OFF: assert property (reg_write && reg_addr == 8'h15 && reg_wdata[7:6] == 2'h0
    ##1 !reg_write[*2] |=> !mic_supply_enable)
    else $error("mic supply pin not disabled");
  AST_POWER_LOW: assert property (!converter_power_control[*4] |=> converter_shutdown)
    else $error("converter not shut down");
  AST_DUAL_USE: assert property (reg_write && reg_addr == 8'h14 && reg_wdata[6]
    |=> serial_out_is_input && serial_out_function == 4'h0)
    else $error("dual use not applied");
  AST_OUT_FUNCTION: assert property (!serial_out_is_input
    |-> serial_out_function == out_function_select)
    else $error("serial out function not followed");
endmodule : pin_routing_checker
bind audio_interface_pin_routing pin_routing_checker chk (.*);
`default_nettype wire

// [verif/density_mic_model.sv]
// pulse-density microphone pair with its clock
`timescale 1ns/1ps
`default_nettype none
module density_mic_model (
  // clock and control
  input wire logic clk,
  input wire logic run,
  input wire logic hi_val,
  // microphone side
  output logic mod_clock,
  output logic mic_data
);
  logic [2:0] phase;
  initial
  begin
    phase = 3'h0;
    mod_clock = 1'b0;
    mic_data = 1'b0;
  end
  // clock stands low between bursts, released data line keeps moving
  always @(posedge clk)
  begin
    if (!run)
    begin
      phase <= 3'h0;
      mod_clock <= 1'b0;
      mic_data <= ~mic_data;
    end
    else
    begin
      phase <= phase + 3'h1;
      if (phase[1:0] == 2'h3)
        mod_clock <= ~mod_clock;
      if (phase[1:0] == 2'h1)
        mic_data <= mod_clock ? hi_val : ~hi_val;
    end
  end
endmodule : density_mic_model
`default_nettype wire

// [verif/tb_audio_interface_pin_routing.sv]
// self-checking bench for the pin routing block
`timescale 1ns/1ps
`default_nettype none
module tb_audio_interface_pin_routing
  import pin_routing_pkg::*;
;
  logic clk, rst_n, reg_write, pwr, run, fok, dok, ex;
  logic [7:0] reg_addr, reg_wdata, rdata;
  logic [3:0] ofs, ds, dss, sof, strobes;
  logic [6:0] lvl, mmask, pins;
  logic mic_data, mod_clk, pdi, sec_en, sfs, sbc, sdi, sdiv, sdi2, sdi2v, c1d, c2d, shut, aux, mic, soi;
  logic [1:0] sc;
  int bad_count = 0;
  int n_checks = 0;
  logic [7:0] addrs [5] = '{addr_clock_routing, addr_input_routing, addr_density_config, addr_pin_misc,
    addr_mic_supply};
  logic [7:0] rstv [5] = '{reset_clock_routing, reset_input_routing, reset_density_config, reset_pin_misc,
    reset_mic_supply};
  logic [7:0] masks [5] = '{mask_clock_routing, mask_input_routing, mask_density_config, mask_pin_misc,
    mask_mic_supply};
  assign pins = (lvl & ~mmask) | ({7{mic_data}} & mmask);
  density_mic_model mics (.clk(clk), .run(run), .hi_val(1'b1), .mod_clock(mod_clk), .mic_data(mic_data));
  audio_interface_pin_routing dut (.clk(clk), .rst_n(rst_n), .reg_write(reg_write), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(rdata), .multi_pin_one(pins[0]), .input_pin_two(pins[1]),
    .input_pin_one(pins[2]), .serial_in_pin(pins[3]), .serial_out_pin_in(pins[4]), .primary_frame_sync(pins[5]),
    .primary_bit_clock(pins[6]), .density_mod_clock(mod_clk), .converter_power_control(pwr),
    .out_function_select(ofs), .primary_data_in(pdi), .secondary_enable(sec_en), .secondary_frame_sync(sfs),
    .secondary_bit_clock(sbc), .secondary_data_in(sdi), .secondary_data_in_valid(sdiv),
    .secondary_data_in2(sdi2), .secondary_data_in2_valid(sdi2v), .chan1_digital(c1d), .chan2_digital(c2d),
    .density_sample(ds), .density_sample_strobe(dss), .converter_shutdown(shut),
    .aux_function_enable(aux), .mic_supply_enable(mic), .serial_out_is_input(soi), .serial_out_function(sof));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_cyc
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_write = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_write = 1'b0;
    @(negedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr = a;
    #2;
    check(rdata, exp);
    @(negedge clk);
  endtask : rd
  function automatic logic [6:0] pin_mask(input logic [2:0] c);
    case (c)
      3'h1, 3'h2, 3'h3: pin_mask = 7'h01 << (c - 3'h1);
      3'h4: pin_mask = 7'h10;
      3'h5: pin_mask = 7'h68;
      default: pin_mask = 7'h00;
    endcase
  endfunction : pin_mask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run
  initial
  begin
    #200000;
    bad_count++;
    complete_run();
  end
  initial
  begin
    rst_n = 1'b0;
    reg_write = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    pwr = 1'b1;
    run = 1'b0;
    ofs = 4'h0;
    lvl = 7'h00;
    mmask = 7'h00;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      rd(addrs[i], rstv[i]);
      wr(addrs[i], masks[i]);
      rd(addrs[i], masks[i]);
      wr(addrs[i], rstv[i]);
    end
    wr(8'h16, 8'hff);
    rd(8'h16, 8'h00);
    $display("test registers done");
    wr(addr_pin_misc, 8'h40);
    check({3'h0, soi, sof}, 8'h10);
    for (int c = 0; c < 8; c++)
      for (int v = 0; v < 2; v++)
      begin
        wr(addr_clock_routing, {1'b1, c[2:0], c[2:0], 1'b0});
        wr(addr_input_routing, {c[2:0], c[2:0], 2'b00});
        lvl = pin_mask(c[2:0]) ^ {7{~v[0]}};
        wait_cyc(4);
        fok = (c inside {1, 2, 3, 5});
        dok = (c inside {[1:5]});
        check({5'h0, sec_en, sfs, sbc}, {5'h0, fok, fok & v[0], fok & v[0]});
        check({4'h0, sdi, sdiv, sdi2, sdi2v}, {4'h0, dok & v[0], dok, dok & v[0], dok});
        check({7'h0, pdi}, {7'h0, lvl[3]});
      end
    wr(addr_clock_routing, 8'h00);
    lvl = 7'h7f;
    wait_cyc(4);
    check({6'h0, pdi, sec_en}, 8'h00);
    wr(addr_pin_misc, 8'h00);
    ofs = 4'h7;
    #2;
    check({3'h0, soi, sof}, 8'h07);
    @(negedge clk);
    ofs = 4'h1;
    #2;
    check({3'h0, soi, sof}, 8'h11);
    @(negedge clk);
    $display("test serial routing done");
    for (int s = 0; s < 5; s++)
      for (int e = 0; e < 2; e++)
      begin
        sc = (s == 4) ? 2'h3 : s[1:0];
        wr(addr_pin_misc, (s == 4) ? 8'h80 : 8'h00);
        wr(addr_density_config, {2'b11, e[0], e[0], sc, sc});
        lvl = 7'h00;
        mmask = (s == 4) ? 7'h08 : pin_mask({1'b0, sc});
        run = 1'b1;
        strobes = 4'h0;
        repeat (40)
        begin
          @(negedge clk);
          strobes |= dss;
        end
        run = 1'b0;
        check({4'h0, strobes}, (s == 0) ? 8'h00 : 8'h0f);
        check({6'h0, c1d, c2d}, 8'h03);
        if (s != 0)
          check({4'h0, ds}, {4'h0, e[0], ~e[0], e[0], ~e[0]});
      end
    mmask = 7'h00;
    $display("test density inputs done");
    for (int p = 0; p < 4; p++)
      for (int v = 0; v < 2; v++)
      begin
        wr(addr_pin_misc, {2'b00, p[1:0], 4'h1});
        wr(addr_mic_supply, {p[1:0], 6'h00});
        lvl = pin_mask({1'b0, p[1:0]}) ^ {7{~v[0]}};
        wait_cyc(4);
        ex = (p != 0) && v[0];
        check({5'h0, shut, mic, aux}, {5'h0, ex, ex, 1'b1});
      end
    wr(addr_pin_misc, 8'h00);
    pwr = 1'b0;
    wait_cyc(5);
    check({7'h0, shut}, 8'h01);
    $display("test misc pins done");
    complete_run();
  end
endmodule : tb_audio_interface_pin_routing
`default_nettype wire
